/* File: inc/udp_session_control_map.vh */
// Register map, field layout and constants of the UDP session controller.
`ifndef UDP_SESSION_CONTROL_MAP_VH
`define UDP_SESSION_CONTROL_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CFG         8'h00
`define OFS_PORT        8'h04
`define OFS_TMO         8'h08
`define OFS_CMD         8'h0c
`define OFS_STAT        8'h10
`define OFS_RIP         8'h14
`define OFS_RPORT       8'h18
`define OFS_TRUST0      8'h20
`define OFS_TRUST_LAST  8'h2c

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define CFG_PSEL_LO     0
`define CFG_PSEL_HI     1
`define CFG_DTRO_LO     2
`define CFG_DTRO_HI     3
`define CFG_TESC        4
`define CFG_AREG        5
`define CFG_AANS        6
`define CFG_TRUST       7
`define CFG_NEI_LO      8
`define CFG_NEI_HI      10
`define CFG_RESET       32'h0000_0110

// ----------------------------------------------------------------
// Command bits, status bits
// ----------------------------------------------------------------
`define CMD_ONLINE      0
`define CMD_HOOK0       1
`define CMD_HOOK1       2
`define CMD_REGNOW      3
`define ST_CMD          0
`define ST_DATA         1
`define ST_ONLINE       2
`define ST_REG          3
`define ST_DCD          4
`define ST_SIG_LO       8
`define ST_SIG_HI       9

// ----------------------------------------------------------------
// Values and limits
// ----------------------------------------------------------------
`define PSEL_UDP        2'h0
`define DTRO_KEEP       2'h1
`define DTRO_CLOSE      2'h2
`define SIG_ACQUIRED    2'h3
`define PORT_MIN        16'h0401
`define PORT_MAX        16'h1387
`define PORT_RESET      16'h0834
`define TMO_MAX         5'h14
`define NEI_MIN         3'h1
`define NEI_MAX         3'h4
`define TRUST_N         4

// ----------------------------------------------------------------
// Result codes to the host
// ----------------------------------------------------------------
`define RES_OK          3'h0
`define RES_CONNECT     3'h1
`define RES_RING        3'h2
`define RES_CONNECT_IP  3'h3
`define RES_ERROR       3'h4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   5
`define SEC_NS          1000000000
`define MIN_SECS        6'h3c

`endif

/* File: rtl/udp_session_control.v */
// UDP session controller: escape, close, timeout and server answer.
//
// Overview of operation
// - DTR option 1 drop: command state, session kept
// - DTR option 2 drop: close, deregister, command
// - Auto-registration keeps registration on option 2
// - Online command resumes data with CONNECT
// - Hook 0 or 1 closes; manual also deregisters
// - Hook 1 deregisters, inhibits auto until rewrite
// - Inactivity timeout 1-20 minutes closes with OK
// - Packet service 0 enables UDP stack
// - Listen port 1025-4999, default 2100, filters
// - Auto-answer 1 arms, session opens on packet
// - Auto-answer 0 stops new server sessions
// - Trusted filter drops unknown sources, empty passes
// - RING, CONNECT with caller, then packet
// - Latest accepted source becomes reply address
// - Command state online stalls network packets
// - Auto-registered session close keeps auto-answer, registration except on hook 1
// - Identity index 1-4 then register now
// - Channel acquisition reports value 3
// - Timed escape enable 1 default, keeps session
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "udp_session_control_map.vh"

module udp_session_control
#(
	parameter SEC_CYCLES = `SEC_NS / `CLK_PERIOD_NS
)
(
	// Clock and reset
	input  wire        clk_sys,
	input  wire        nrst,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	// Host line signals
	input  wire        dtr,
	input  wire        timed_escape_seen,
	input  wire        host_tx,
	output wire        dcd,
	output reg         res_valid,
	output reg  [2:0]  res_code,
	output reg         host_pkt_valid,
	// Network packets and registration
	input  wire        pkt_valid,
	input  wire [31:0] pkt_src_ip,
	input  wire [15:0] pkt_src_port,
	input  wire [15:0] pkt_dst_port,
	output wire        pkt_ready,
	input  wire        chan_acquired,
	input  wire        net_reg_done,
	output reg         net_reg_req,
	output reg  [2:0]  net_reg_nei,
	output reg         net_dereg_req
);

	// ----------------------------------------------------------------
	// Answer sequencer states
	// ----------------------------------------------------------------
	localparam [1:0] SQ_IDLE = 2'd0;
	localparam [1:0] SQ_RING = 2'd1;
	localparam [1:0] SQ_CONN = 2'd2;
	localparam [1:0] SQ_DELV = 2'd3;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	reg        wr_pend_q;
	reg [7:0]  wr_addr_q;
	reg [31:0] cfg_q;
	reg [15:0] port_q;
	reg [4:0]  tmo_q;
	reg [31:0] trust_q [0:`TRUST_N-1];
	reg [31:0] rip_q;
	reg [15:0] rport_q;
	reg        cmd_q;
	reg        data_q;
	reg        online_q;
	reg        reg_q;
	reg        reg_busy_q;
	reg        areg_inh_q;
	reg        dtr_q;
	reg [1:0]  sq_q;
	reg [31:0] sec_cnt_q;
	reg [5:0]  sec_q;
	reg [4:0]  min_q;

	wire       addr_ok = hsel & hready & htrans[1];
	wire       wr_cfg  = wr_pend_q & (wr_addr_q == `OFS_CFG);
	wire       wr_cmd  = wr_pend_q & (wr_addr_q == `OFS_CMD);
	wire       go_on   = wr_cmd & hwdata[`CMD_ONLINE];
	wire       hook0   = wr_cmd & hwdata[`CMD_HOOK0];
	wire       hook1   = wr_cmd & hwdata[`CMD_HOOK1];
	wire       regnow  = wr_cmd & hwdata[`CMD_REGNOW];

	wire [1:0] psel  = cfg_q[`CFG_PSEL_HI:`CFG_PSEL_LO];
	wire [1:0] dtro  = cfg_q[`CFG_DTRO_HI:`CFG_DTRO_LO];
	wire       tesc  = cfg_q[`CFG_TESC];
	wire       areg  = cfg_q[`CFG_AREG];
	wire       aans  = cfg_q[`CFG_AANS];
	wire       trust = cfg_q[`CFG_TRUST];
	wire [2:0] network_identity   = cfg_q[`CFG_NEI_HI:`CFG_NEI_LO];

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	function trust_index_ok;
		input [7:0] a;
		begin
			trust_index_ok = (a >= `OFS_TRUST0) && (a <= `OFS_TRUST_LAST)
				&& (a[1:0] == 2'b00);
		end
	endfunction

	always @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end
		else
		begin
			wr_pend_q <= addr_ok & hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	// Read data is fetched in the address phase so it stands from a
	// flop for the whole data phase; no wait states are ever inserted.
	always @(posedge clk_sys)
	begin
		if (!nrst)
			hrdata <= 32'h0000_0000;
		else if (addr_ok & ~hwrite)
		begin
			hrdata <= 32'h0000_0000;
			if (haddr[31:8] == 24'h00_0000)
			begin
				case (haddr[7:0])
				`OFS_CFG:   hrdata <= cfg_q;
				`OFS_PORT:  hrdata <= {16'h0000, port_q};
				`OFS_TMO:   hrdata <= {27'h000_0000, tmo_q};
				`OFS_STAT:  hrdata <= {22'h00_0000,
					chan_acquired ? `SIG_ACQUIRED : 2'h0,
					3'h0, dcd, reg_q, online_q, data_q, cmd_q};
				`OFS_RIP:   hrdata <= rip_q;
				`OFS_RPORT: hrdata <= {16'h0000, rport_q};
				default:
					if (trust_index_ok(haddr[7:0]))
						hrdata <= trust_q[haddr[3:2]];
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Settings
	// ----------------------------------------------------------------
	wire [15:0] wport = hwdata[15:0];

	always @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			cfg_q  <= `CFG_RESET;
			port_q <= `PORT_RESET;
			tmo_q  <= 5'h00;
		end
		else if (wr_pend_q)
		begin
			if (wr_cfg)
				cfg_q <= hwdata;
			if ((wr_addr_q == `OFS_PORT) && (wport >= `PORT_MIN)
				&& (wport <= `PORT_MAX))
				port_q <= wport;
			if ((wr_addr_q == `OFS_TMO) && (hwdata[31:5] == 27'h0)
				&& (hwdata[4:0] <= `TMO_MAX))
				tmo_q <= hwdata[4:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `TRUST_N; gi = gi + 1)
		begin : g_trust
			always @(posedge clk_sys)
			begin
				if (!nrst)
					trust_q[gi] <= 32'h0000_0000;
				else if (wr_pend_q && trust_index_ok(wr_addr_q)
					&& (wr_addr_q[3:2] == gi))
					trust_q[gi] <= hwdata;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Packet acceptance
	// ----------------------------------------------------------------
	// A zero entry marks an unused slot; an all-zero list passes all.
	reg        hit;
	reg        empty;
	integer    k;

	always @*
	begin
		hit   = 1'b0;
		empty = 1'b1;
		for (k = 0; k < `TRUST_N; k = k + 1)
		begin
			if (trust_q[k] != 32'h0000_0000)
				empty = 1'b0;
			if ((trust_q[k] != 32'h0000_0000) && (trust_q[k] == pkt_src_ip))
				hit = 1'b1;
		end
	end

	// Packets wait at the network while the host holds command state
	// with the session open, and while the answer sequence runs.
	assign pkt_ready = ~(online_q & cmd_q) & (sq_q == SQ_IDLE)
		& (online_q | aans);

	wire src_ok = ~trust | empty | hit;
	wire acc = pkt_valid & pkt_ready & (psel == `PSEL_UDP)
		& src_ok & (pkt_dst_port == port_q);
	wire answer = acc & ~online_q & aans;

	always @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			rip_q   <= 32'h0000_0000;
			rport_q <= 16'h0000;
		end
		else if (acc)
		begin
			rip_q   <= pkt_src_ip;
			rport_q <= pkt_src_port;
		end
	end

	// ----------------------------------------------------------------
	// Inactivity timer
	// ----------------------------------------------------------------
	wire sec_tick = (sec_cnt_q == SEC_CYCLES - 1);
	wire min_tick = sec_tick & (sec_q == `MIN_SECS - 6'h01);
	wire act      = acc | host_tx | ~online_q | ~data_q;
	wire idle_out = (tmo_q != 5'h00) & min_tick
		& (min_q == tmo_q - 5'h01);

	always @(posedge clk_sys)
	begin
		if (!nrst || act || tmo_q == 5'h00)
		begin
			sec_cnt_q <= 32'h0000_0000;
			sec_q     <= 6'h00;
			min_q     <= 5'h00;
		end
		else
		begin
			sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h1;
			if (sec_tick)
				sec_q <= min_tick ? 6'h00 : sec_q + 6'h01;
			if (min_tick)
				min_q <= min_q + 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// Session state
	// ----------------------------------------------------------------
	wire dtr_drop = dtr_q & ~dtr & data_q & online_q;
	wire esc_keep = (dtr_drop & (dtro == `DTRO_KEEP))
		| (timed_escape_seen & tesc & data_q & online_q);
	wire esc_close = dtr_drop & (dtro == `DTRO_CLOSE);
	wire close = esc_close | hook0 | hook1 | idle_out;
	// Manual registration drops the link on every close path except the
	// inactivity timeout; the automatic mode keeps it unless hook 1 forces it off.
	wire dereg = hook1 | ((esc_close | hook0) & ~areg);

	assign dcd = online_q;

	always @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			cmd_q          <= 1'b1;
			data_q         <= 1'b0;
			online_q       <= 1'b0;
			dtr_q          <= 1'b0;
			sq_q           <= SQ_IDLE;
			res_valid      <= 1'b0;
			res_code       <= `RES_OK;
			host_pkt_valid <= 1'b0;
		end
		else
		begin
			dtr_q          <= dtr;
			res_valid      <= 1'b0;
			host_pkt_valid <= 1'b0;
			case (sq_q)
			SQ_IDLE:
				if (close)
				begin
					online_q <= 1'b0;
					data_q   <= 1'b0;
					cmd_q    <= 1'b1;
					if (idle_out | hook0 | hook1)
					begin
						res_valid <= 1'b1;
						res_code  <= `RES_OK;
					end
				end
				else if (esc_keep)
				begin
					data_q <= 1'b0;
					cmd_q  <= 1'b1;
				end
				else if (go_on)
				begin
					res_valid <= 1'b1;
					if (online_q)
					begin
						res_code <= `RES_CONNECT;
						cmd_q    <= 1'b0;
						data_q   <= 1'b1;
					end
					else
						res_code <= `RES_ERROR;
				end
				else if (answer)
				begin
					res_valid <= 1'b1;
					res_code  <= `RES_RING;
					sq_q      <= SQ_RING;
				end
				else if (acc)
					host_pkt_valid <= 1'b1;
			SQ_RING:
			begin
				res_valid <= 1'b1;
				res_code  <= `RES_CONNECT_IP;
				online_q  <= 1'b1;
				sq_q      <= SQ_CONN;
			end
			SQ_CONN:
			begin
				cmd_q  <= 1'b0;
				data_q <= 1'b1;
				sq_q   <= SQ_DELV;
			end
			SQ_DELV:
			begin
				host_pkt_valid <= 1'b1;
				sq_q           <= SQ_IDLE;
			end
			default:
				sq_q <= SQ_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Network registration
	// ----------------------------------------------------------------
	wire nei_ok   = (network_identity >= `NEI_MIN) && (network_identity <= `NEI_MAX);
	wire auto_go  = areg & ~areg_inh_q & ~reg_q & ~reg_busy_q;
	wire man_go   = regnow & nei_ok & ~reg_q & ~reg_busy_q;

	always @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			reg_q         <= 1'b0;
			reg_busy_q    <= 1'b0;
			areg_inh_q    <= 1'b0;
			net_reg_req   <= 1'b0;
			net_reg_nei   <= 3'h0;
			net_dereg_req <= 1'b0;
		end
		else
		begin
			net_reg_req   <= 1'b0;
			net_dereg_req <= 1'b0;
			if (hook1)
				areg_inh_q <= 1'b1;
			else if (wr_cfg & hwdata[`CFG_AREG])
				areg_inh_q <= 1'b0;
			if (dereg & (sq_q == SQ_IDLE))
			begin
				reg_q         <= 1'b0;
				reg_busy_q    <= 1'b0;
				net_dereg_req <= 1'b1;
			end
			else if (reg_busy_q)
			begin
				if (net_reg_done)
				begin
					reg_q      <= 1'b1;
					reg_busy_q <= 1'b0;
				end
			end
			else if (auto_go | man_go)
			begin
				reg_busy_q  <= 1'b1;
				net_reg_req <= 1'b1;
				net_reg_nei <= network_identity;
			end
		end
	end

endmodule // udp_session_control

`default_nettype wire

/* File: sim/net_far_end.sv */
// Network far end: packet offers and registration answers.
`timescale 1ns/10ps
`default_nettype none
module net_far_end (
	// Clock
	input wire logic        clk_sys,
	// Registration
	input wire logic        net_reg_req,
	input wire logic [2:0]  net_reg_nei,
	output logic            net_reg_done,
	// Packet offer
	input wire logic        pkt_ready,
	output logic            pkt_valid,
	output logic [31:0]     pkt_src_ip,
	output logic [15:0]     pkt_src_port,
	output logic [15:0]     pkt_dst_port
);
	// ----------------
	// Registration
	// ----------------
	int         lag = 3;
	int         cnt = 0;
	logic [2:0] last_nei = 3'h0;
	initial
	begin
		net_reg_done = 1'b0;
		pkt_valid = 1'b0;
		pkt_src_ip = 32'h0000_0000;
		pkt_src_port = 16'h0000;
		pkt_dst_port = 16'h0000;
	end
	// Repeated requests do not restart the lag, or it could never end.
	always @(posedge clk_sys)
	begin
		if (net_reg_req === 1'b1 && cnt == 0)
		begin
			last_nei <= net_reg_nei;
			cnt <= lag;
		end
		else if (cnt > 0)
			cnt <= cnt - 1;
		net_reg_done <= (cnt == 1);
	end
	// ----------------
	// Packet offer
	// ----------------
	task automatic send(input logic [31:0] ip, input logic [15:0] sp,
		input logic [15:0] dp, input int bound, output bit tk);
		int n;
		pkt_valid <= 1'b1;
		pkt_src_ip <= ip;
		pkt_src_port <= sp;
		pkt_dst_port <= dp;
		tk = 0;
		for (n = 0; n < bound && !tk; n++)
		begin
			@(posedge clk_sys);
			tk = (pkt_ready === 1'b1);
		end
		// Released fields must not look like a valid packet.
		pkt_valid <= 1'b0;
		pkt_src_ip <= ~ip;
		pkt_src_port <= ~sp;
		pkt_dst_port <= ~dp;
	endtask
endmodule // net_far_end
`default_nettype wire

/* File: sim/udp_session_control_assertions.sv */
// Port checks of the UDP session controller.
`timescale 1ns/10ps
`default_nettype none
`include "udp_session_control_map.vh"
module udp_session_control_assertions (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       nrst,
	// Bus answer
	input wire logic       hreadyout,
	input wire logic       hresp,
	// Session side
	input wire logic       dcd,
	input wire logic       res_valid,
	input wire logic [2:0] res_code,
	input wire logic       host_pkt_valid,
	input wire logic       pkt_ready,
	input wire logic       net_reg_req,
	input wire logic [2:0] net_reg_nei,
	input wire logic       net_dereg_req
);
	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	wire ring_now = res_valid && res_code == `RES_RING;

	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_reset_quiet: assert property ($rose(nrst) |-> !dcd && !res_valid
		&& !pkt_ready && !net_reg_req && !net_dereg_req)
		else $error("outputs active after reset");
	a_ring_connect: assert property (ring_now |=>
		res_valid && res_code == `RES_CONNECT_IP && dcd ##2 host_pkt_valid)
		else $error("answer sequence broken");
	a_ring_offline: assert property (ring_now |-> !dcd)
		else $error("ring while session open");
	a_rise_caller: assert property ($rose(dcd) |-> res_valid
		&& res_code == `RES_CONNECT_IP && $past(res_code) == `RES_RING)
		else $error("carrier rose without caller report");
	a_pass_online: assert property (host_pkt_valid |-> dcd)
		else $error("packet passed with no session");
	a_answer_stall: assert property (ring_now |-> !pkt_ready
		##1 !pkt_ready)
		else $error("packet taken during answer");
	a_nei_range: assert property (net_reg_req |->
		net_reg_nei >= `NEI_MIN && net_reg_nei <= `NEI_MAX)
		else $error("identity out of range");
endmodule // udp_session_control_assertions

bind udp_session_control udp_session_control_assertions u_chk (
	.clk_sys(clk_sys),
	.nrst(nrst),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.dcd(dcd),
	.res_valid(res_valid),
	.res_code(res_code),
	.host_pkt_valid(host_pkt_valid),
	.pkt_ready(pkt_ready),
	.net_reg_req(net_reg_req),
	.net_reg_nei(net_reg_nei),
	.net_dereg_req(net_dereg_req)
);
`default_nettype wire

/* File: sim/udp_session_control_tb.sv */
// Self-checking bench of the UDP session controller.
`timescale 1ns/10ps
`default_nettype none
`include "udp_session_control_map.vh"
module udp_session_control_tb;
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic        dtr = 1'b1;
	logic        timed_escape_seen = 1'b0;
	logic        host_tx = 1'b0;
	logic        chan_acq = 1'b0;
	wire  [31:0] hrdata, pkt_src_ip;
	wire  [15:0] pkt_src_port, pkt_dst_port;
	wire  [2:0]  res_code, net_reg_nei;
	wire         hreadyout, hresp, dcd, res_valid, host_pkt_valid;
	wire         pkt_valid, pkt_ready, net_reg_done, net_reg_req;
	wire         net_dereg_req;
	int          miscompares = 0;
	int          check_count = 0;
	int          to_host = 0;
	int          dereg_n = 0;
	logic [2:0]  seen[$];
	logic [31:0] rnd = 32'ha7f9a27e;
	logic [31:0] v, ip1;
	bit          tk;

	udp_session_control #(.SEC_CYCLES(4)) u_dut (
		.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .dtr(dtr), .timed_escape_seen(timed_escape_seen), .host_tx(host_tx),
		.dcd(dcd), .res_valid(res_valid), .res_code(res_code),
		.host_pkt_valid(host_pkt_valid), .pkt_valid(pkt_valid),
		.pkt_src_ip(pkt_src_ip), .pkt_src_port(pkt_src_port),
		.pkt_dst_port(pkt_dst_port), .pkt_ready(pkt_ready),
		.chan_acquired(chan_acq), .net_reg_done(net_reg_done),
		.net_reg_req(net_reg_req), .net_reg_nei(net_reg_nei),
		.net_dereg_req(net_dereg_req));
	net_far_end u_net (
		.clk_sys(clk_sys), .net_reg_req(net_reg_req),
		.net_reg_nei(net_reg_nei), .net_reg_done(net_reg_done),
		.pkt_ready(pkt_ready), .pkt_valid(pkt_valid),
		.pkt_src_ip(pkt_src_ip), .pkt_src_port(pkt_src_port),
		.pkt_dst_port(pkt_dst_port));

	// ----------------
	// Clock, result log and helpers
	// ----------------
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		if (res_valid === 1'b1)
			seen.push_back(res_code);
		if (host_pkt_valid === 1'b1)
			to_host++;
		if (net_dereg_req === 1'b1)
			dereg_n++;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, e);
		check_count++;
		if (got !== e)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
			if (n > 20)
			begin
				miscompares++;
				close_out();
			end
		end
		while (hreadyout !== 1'b1);
	endtask
	task automatic bus(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		v = hrdata;
	endtask
	task automatic rc(input string nm, input logic [31:0] a, e);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, v, e);
	endtask
	task automatic er(input logic [2:0] c, input int bound);
		int n;
		for (n = 0; n < bound && seen.size() == 0; n++)
			@(posedge clk_sys);
		chk("result", seen.size() ? seen.pop_front() : 3'h7, c);
	endtask
	task automatic no_res;
		cyc(8);
		chk("result count", seen.size(), 0);
	endtask
	task automatic poll_reg;
		int n;
		v = 32'h0000_0000;
		for (n = 0; n < 50 && v[`ST_REG] !== 1'b1; n++)
			bus(1'b0, `OFS_STAT, 32'h0000_0000);
		chk("registered", v[`ST_REG], 1'b1);
	endtask
	task automatic sess(input logic [31:0] ip);
		u_net.send(ip, 16'h1234, 16'h1387, 20, tk);
		er(`RES_RING, 20);
		er(`RES_CONNECT_IP, 20);
	endtask

	// ----------------
	// Scenarios
	// ----------------
	initial
	begin
		cyc(10);
		nrst <= 1'b1;
		cyc(1);
		rc("config", `OFS_CFG, `CFG_RESET);
		rc("timeout", `OFS_TMO, 32'h0000_0000);
		rc("port", `OFS_PORT, 32'h0000_0834);
		rc("unmapped", 32'h0000_0040, 32'h0000_0000);
		rc("status", `OFS_STAT, 32'h0000_0001);
		chan_acq <= 1'b1;
		bus(1'b1, `OFS_PORT, 32'h0000_0400);
		rc("port", `OFS_PORT, 32'h0000_0834);
		bus(1'b1, `OFS_PORT, 32'h0000_1387);
		rc("port", `OFS_PORT, 32'h0000_1387);
		bus(1'b1, `OFS_CFG, 32'h0000_0250);
		u_net.lag = 9;
		bus(1'b1, `OFS_CMD, 32'h0000_0008);
		poll_reg();
		chk("identity", u_net.last_nei, 32'h0000_0002);
		rc("status", `OFS_STAT, 32'h0000_0309);
		rnd = lfsr(rnd);
		ip1 = rnd;
		u_net.send(ip1, rnd[15:0], 16'h0834, 20, tk);
		no_res();
		chk("to host", to_host, 0);
		u_net.send(ip1, rnd[15:0], 16'h1387, 20, tk);
		er(`RES_RING, 20);
		er(`RES_CONNECT_IP, 20);
		rc("reply ip", `OFS_RIP, ip1);
		rc("reply port", `OFS_RPORT, {16'h0000, rnd[15:0]});
		rnd = lfsr(rnd);
		u_net.send(rnd, rnd[31:16], 16'h1387, 20, tk);
		cyc(3);
		rc("reply ip", `OFS_RIP, rnd);
		chk("to host", to_host, 2);
		timed_escape_seen <= 1'b1;
		cyc(1);
		timed_escape_seen <= 1'b0;
		cyc(2);
		rc("status", `OFS_STAT, 32'h0000_031d);
		u_net.send(rnd, rnd[15:0], 16'h1387, 6, tk);
		chk("taken", tk, 1'b0);
		bus(1'b1, `OFS_CMD, 32'h0000_0001);
		er(`RES_CONNECT, 8);
		rc("status", `OFS_STAT, 32'h0000_031e);
		bus(1'b1, `OFS_CFG, 32'h0000_0244);
		dtr <= 1'b0;
		cyc(3);
		rc("status", `OFS_STAT, 32'h0000_031d);
		dtr <= 1'b1;
		bus(1'b1, `OFS_CMD, 32'h0000_0002);
		er(`RES_OK, 8);
		rc("status", `OFS_STAT, 32'h0000_0301);
		chk("deregs", dereg_n, 1);
		bus(1'b1, `OFS_CMD, 32'h0000_0001);
		er(`RES_ERROR, 8);
		bus(1'b1, `OFS_TRUST0, ip1);
		bus(1'b1, `OFS_CFG, 32'h0000_02e8);
		poll_reg();
		u_net.send(lfsr(rnd), 16'h1234, 16'h1387, 20, tk);
		no_res();
		chk("to host", to_host, 2);
		sess(ip1);
		bus(1'b1, `OFS_TMO, 32'h0000_0001);
		cyc(200);
		host_tx <= 1'b1;
		cyc(1);
		host_tx <= 1'b0;
		cyc(100);
		chk("result count", seen.size(), 0);
		er(`RES_OK, 400);
		cyc(2);
		chk("carrier", dcd, 1'b0);
		rc("status", `OFS_STAT, 32'h0000_0309);
		sess(ip1);
		cyc(3);
		dtr <= 1'b0;
		cyc(3);
		rc("status", `OFS_STAT, 32'h0000_0309);
		chk("deregs", dereg_n, 1);
		dtr <= 1'b1;
		sess(ip1);
		bus(1'b1, `OFS_CMD, 32'h0000_0004);
		er(`RES_OK, 8);
		cyc(20);
		rc("status", `OFS_STAT, 32'h0000_0301);
		chk("deregs", dereg_n, 2);
		bus(1'b1, `OFS_CFG, 32'h0000_02a8);
		u_net.send(ip1, 16'h1234, 16'h1387, 8, tk);
		chk("taken", tk, 1'b0);
		poll_reg();
		bus(1'b1, `OFS_CFG, 32'h0000_0248);
		sess(ip1);
		cyc(3);
		dtr <= 1'b0;
		cyc(3);
		rc("status", `OFS_STAT, 32'h0000_0301);
		chk("deregs", dereg_n, 3);
		close_out();
	end
endmodule // udp_session_control_tb
`default_nettype wire
